// ===== design/ee_access_guard.sv
`timescale 1ns/1ps
// What this block does
// - Code protect refuses external programmer accesses
// - CPU accesses ignore code protect
// - Write enable cleared at power-up
// - Writes blocked during power-up timer
// - CPU write needs enable plus completed unlock; external writes need neither
// - Write start stays set until done
// - Byte address, high byte beyond 256
// - Byte array, each location rewritable
module ee_access_guard
	import ee_guard_pkg::*;
#(
	parameter int AW = 8,
	parameter int PWRT_CNT = PWRT_CYCLES,
	parameter int WRITE_CNT = WRITE_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire ee_guard_pkg::ctl_t ctl_i,
	input wire logic [7:0] key_data_i,
	input wire logic [7:0] addr_low_i,
	input wire logic [7:0] addr_high_i,
	input wire logic [7:0] wdata_i,
	input wire logic code_protect_i,
	input wire logic ext_req_i,
	input wire logic ext_we_i,
	input wire logic [7:0] ext_wdata_i,
	output logic [7:0] data_o,
	output logic wr_en_o,
	output logic rd_busy_o,
	output logic wr_busy_o,
	output logic pwrt_active_o,
	output logic ext_refused_o
);
	import ee_guard_pkg::*;

	// ****************************************************************
	// Elaboration checks
	// ****************************************************************
	if (AW < 8 || AW > 16)
	begin : g_bad_aw
		$error("AW must lie between 8 and 16");
	end
	// The held-bit check needs at least two busy cycles per write
	if (PWRT_CNT < 1 || WRITE_CNT < 2)
	begin : g_bad_cnt
		$error("Counts too small for the timers");
	end

	// Timer widths cover the larger of the two counts
	localparam int TW = $clog2((PWRT_CNT > WRITE_CNT ? PWRT_CNT :
		WRITE_CNT) + 1);

	// ****************************************************************
	// State
	// ****************************************************************
	unlock_t unl_r, unl_nxt; // Unlock sequence progress
	engine_t eng_r, eng_nxt; // Access engine
	logic wr_en_r, wr_en_nxt; // write_enable_bit
	logic rd_r, rd_nxt; // read_start_bit
	logic wr_r, wr_nxt; // write_start_bit
	logic [TW-1:0] pwrt_r, pwrt_nxt; // Power-up timer
	logic pwrt_act_r, pwrt_act_nxt; // Timer running, kept in a flop
	logic [TW-1:0] wcnt_r, wcnt_nxt; // Write duration timer
	logic [7:0] data_r, data_nxt; // Data register
	logic [7:0] wbuf_r, wbuf_nxt; // Byte latched for the write
	logic ext_ref_r, ext_ref_nxt; // External access refused flag
	logic arr_we; // Array write strobe
	logic [AW-1:0] arr_addr; // Array address
	logic [7:0] arr_wdata; // Array write data
	logic [7:0] arr_rdata; // Array read data
	logic ext_ok; // External access allowed

	// Select both clear means data array space
	function automatic logic data_space(input ctl_t c);
		return !c.mem_space_sel && !c.cfg_space_sel;
	endfunction

	// Address beyond 256 bytes pulls in the high byte
	function automatic logic [AW-1:0] full_addr(input logic [7:0] lo,
		input logic [7:0] hi);
		logic [15:0] a;
		a = {hi, lo};
		return a[AW-1:0];
	endfunction

	// ****************************************************************
	// Next-state logic
	// ****************************************************************
	always_comb
	begin
		unl_nxt = unl_r;
		eng_nxt = eng_r;
		wr_en_nxt = wr_en_r;
		rd_nxt = rd_r;
		wr_nxt = wr_r;
		pwrt_nxt = pwrt_r;
		wcnt_nxt = wcnt_r;
		data_nxt = data_r;
		wbuf_nxt = wbuf_r;
		ext_ref_nxt = 1'b0;
		// Count down the power-up timer once after reset
		if (pwrt_r != '0)
		begin
			pwrt_nxt = pwrt_r - TW'(1);
		end
		// Flag follows the next count so it never lags the timer
		pwrt_act_nxt = (pwrt_nxt != '0);
		// Write enable set and clear by software
		if (ctl_i.wr_en_set)
		begin
			wr_en_nxt = 1'b1;
		end
		else if (ctl_i.wr_en_clr)
		begin
			wr_en_nxt = 1'b0;
		end
		// Unlock key tracking; any other byte restarts it
		if (ctl_i.key_we)
		begin
			if (key_data_i == KEY_FIRST)
			begin
				unl_nxt = UNL_HALF;
			end
			else if (unl_r == UNL_HALF && key_data_i == KEY_SECOND)
			begin
				unl_nxt = UNL_OPEN;
			end
			else
			begin
				unl_nxt = UNL_IDLE;
			end
		end
		// External programmer access is refused under code protect
		if (ext_req_i && code_protect_i)
		begin
			ext_ref_nxt = 1'b1;
		end
		case (eng_r)
			ENG_IDLE:
			begin
				// A write attempt taken while idle uses up the unlock; a start strobe
				// while the engine is busy leaves it, so a later start can still use it
				if (ctl_i.wr_start)
				begin
					unl_nxt = UNL_IDLE;
				end
				if (ctl_i.wr_start && data_space(ctl_i))
				begin
					if (wr_en_r && unl_r == UNL_OPEN
						&& pwrt_r == '0)
					begin
						wr_nxt = 1'b1;
						wbuf_nxt = wdata_i;
						wcnt_nxt = TW'(WRITE_CNT);
						eng_nxt = ENG_WRITE;
					end
				end
				else if (ctl_i.rd_start && data_space(ctl_i))
				begin
					rd_nxt = 1'b1;
					eng_nxt = ENG_READ;
				end
				else if (ext_ok && !ext_we_i)
				begin
					eng_nxt = ENG_READ;
				end
				else if (ext_ok && ext_we_i && pwrt_r == '0)
				begin
					wbuf_nxt = ext_wdata_i;
					wr_nxt = 1'b1;
					wcnt_nxt = TW'(WRITE_CNT);
					eng_nxt = ENG_WRITE;
				end
			end
			ENG_READ:
			begin
				// Registered array data lands one cycle later
				data_nxt = arr_rdata;
				rd_nxt = 1'b0;
				eng_nxt = ENG_IDLE;
			end
			ENG_WRITE:
			begin
				// Bit held while the self-timed write runs
				if (wcnt_r == TW'(1))
				begin
					wr_nxt = 1'b0;
					eng_nxt = ENG_IDLE;
				end
				wcnt_nxt = wcnt_r - TW'(1);
			end
			default:
			begin
				eng_nxt = ENG_IDLE;
			end
		endcase
	end

	// CPU path never looks at code protect; external path does
	assign ext_ok = ext_req_i && !code_protect_i
		&& !ctl_i.wr_start && !ctl_i.rd_start;
	// Array strobe fires in the last write cycle
	assign arr_we = (eng_r == ENG_WRITE) && (wcnt_r == TW'(1));
	assign arr_addr = full_addr(addr_low_i, addr_high_i);
	assign arr_wdata = wbuf_r;

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			unl_r <= UNL_IDLE;
			eng_r <= ENG_IDLE;
			wr_en_r <= WR_EN_RST;
			rd_r <= 1'b0;
			wr_r <= 1'b0;
			pwrt_r <= TW'(PWRT_CNT);
			pwrt_act_r <= 1'b1;
			wcnt_r <= '0;
			data_r <= DATA_RST;
			wbuf_r <= DATA_RST;
			ext_ref_r <= 1'b0;
		end
		else
		begin
			unl_r <= unl_nxt;
			eng_r <= eng_nxt;
			wr_en_r <= wr_en_nxt;
			rd_r <= rd_nxt;
			wr_r <= wr_nxt;
			pwrt_r <= pwrt_nxt;
			pwrt_act_r <= pwrt_act_nxt;
			wcnt_r <= wcnt_nxt;
			data_r <= data_nxt;
			wbuf_r <= wbuf_nxt;
			ext_ref_r <= ext_ref_nxt;
		end
	end

	// Byte-wide storage array
	ee_byte_array #(
		.AW(AW)
	) ee_byte_array_i (
		.clk_i(clk_i),
		.we_i(arr_we),
		.addr_i(arr_addr),
		.wdata_i(arr_wdata),
		.rdata_o(arr_rdata)
	);

	assign data_o = data_r;
	assign wr_en_o = wr_en_r;
	assign rd_busy_o = rd_r;
	assign wr_busy_o = wr_r;
	assign pwrt_active_o = pwrt_act_r;
	assign ext_refused_o = ext_ref_r;

	// ****************************************************************
	// Checks
	// ****************************************************************
	wr_needs_unlock_a: assert property (@(posedge clk_i)
		disable iff (!rst_b_i) $rose(wr_r) |-> $past(unl_r) == UNL_OPEN
		&& $past(wr_en_r))
		else $error("write began without enable and unlock");
	pwrt_blocks_a: assert property (@(posedge clk_i)
		disable iff (!rst_b_i) pwrt_r != '0 |-> !arr_we)
		else $error("array written during power-up timer");
	wr_held_a: assert property (@(posedge clk_i)
		disable iff (!rst_b_i) $rose(wr_r) |-> wr_r[*2])
		else $error("write start bit dropped early");
	wr_clears_a: assert property (@(posedge clk_i)
		disable iff (!rst_b_i) arr_we |=> !wr_r)
		else $error("write start bit not cleared at completion");
	rd_selfclear_a: assert property (@(posedge clk_i)
		disable iff (!rst_b_i) rd_r |=> !rd_r && data_r == $past(arr_rdata))
		else $error("read start bit did not clear with data");
	ext_refuse_a: assert property (@(posedge clk_i)
		disable iff (!rst_b_i) ext_req_i && code_protect_i |=> ext_ref_r
		&& eng_r != ENG_WRITE || $past(eng_r) == ENG_WRITE)
		else $error("protected external access not refused");
	sel_route_a: assert property (@(posedge clk_i)
		disable iff (!rst_b_i) eng_r == ENG_IDLE && ctl_i.rd_start
		&& ctl_i.mem_space_sel && !ctl_i.wr_start |=> !rd_r)
		else $error("read routed outside data space");
	wr_en_reset_a: assert property (@(posedge clk_i)
		!rst_b_i |=> !wr_en_r)
		else $error("write enable not cleared by reset");
endmodule

// ===== design/ee_guard_pkg.sv
package ee_guard_pkg;
	// ****************************************************************
	// Unlock keys and timing
	// ****************************************************************
	localparam logic [7:0] KEY_FIRST = 8'h55; // First unlock byte
	localparam logic [7:0] KEY_SECOND = 8'hAA; // Second unlock byte
	localparam int CLK_PERIOD_NS = 100; // 10 MHz system clock
	localparam int PWRT_US = 64; // Power-up timer period, plain default
	localparam int PWRT_CYCLES = (PWRT_US * 1000) / CLK_PERIOD_NS;
	localparam int WRITE_US = 40; // Self-timed write duration, default
	localparam int WRITE_CYCLES = (WRITE_US * 1000) / CLK_PERIOD_NS;
	// ****************************************************************
	// Control bit reset values
	// ****************************************************************
	localparam logic WR_EN_RST = 1'b0; // Write enable cleared at power-up
	localparam logic [7:0] DATA_RST = 8'h00; // Data register reset

	// Unlock progress
	typedef enum {UNL_IDLE, UNL_HALF, UNL_OPEN} unlock_t;
	// Engine state
	typedef enum {ENG_IDLE, ENG_READ, ENG_WRITE} engine_t;

	// Control strobes from the CPU side
	typedef struct packed {
		logic mem_space_sel; // memory_space_select
		logic cfg_space_sel; // config_space_select
		logic wr_en_set;     // Set write_enable_bit
		logic wr_en_clr;     // Clear write_enable_bit
		logic rd_start;      // Set read_start_bit
		logic wr_start;      // Set write_start_bit
		logic key_we;        // Write to unlock_key_register
	} ctl_t;
endpackage

// ===== design/ee_byte_array.sv
`timescale 1ns/1ps
// Byte array with registered read data
module ee_byte_array #(
	parameter int AW = 8
) (
	input wire logic clk_i,
	input wire logic we_i,
	input wire logic [AW-1:0] addr_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o
);
	// ****************************************************************
	// Storage
	// ****************************************************************
	logic [7:0] mem [2**AW]; // One byte per location

	// Each location is read and rewritten on its own
	always_ff @(posedge clk_i)
	begin
		if (we_i)
		begin
			mem[addr_i] <= wdata_i;
		end
		rdata_o <= mem[addr_i];
	end
endmodule

// ===== verif/test_ee_access_guard.sv
`timescale 1ns/1ps
module test_ee_access_guard;
	import ee_guard_pkg::*;
	// ****************************************************************
	// Signals and bench state
	// ****************************************************************
	localparam int WCNT = 3; // Short write time for simulation
	localparam logic [6:0] P_WSET = 7'h10, P_WCLR = 7'h08, P_RD = 7'h04;
	localparam logic [6:0] P_WR = 7'h02, P_KEY = 7'h01;
	logic clk_i = 1'b0, rst_b_i = 1'b0;
	ctl_t ctl = '0, base = '0; // Base holds the space selects
	logic [7:0] key_d = 8'h00, a_lo = 8'h00, a_hi = 8'h00, wd = 8'h00;
	logic cp = 1'b0, x_req = 1'b0, x_we = 1'b0;
	logic [7:0] x_wd = 8'h00, data_o;
	logic wr_en_o, rd_busy_o, wr_busy_o, pwrt_active_o, ext_refused_o;
	logic [7:0] mem [256]; // Expected array contents
	logic [31:0] seed = 32'h371E;
	int errors = 0, checks = 0, n;
	logic [7:0] ad [8];
	ee_access_guard #(.AW(8), .PWRT_CNT(20), .WRITE_CNT(WCNT))
		ee_access_guard_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .ctl_i(ctl),
		.key_data_i(key_d), .addr_low_i(a_lo), .addr_high_i(a_hi),
		.wdata_i(wd), .code_protect_i(cp), .ext_req_i(x_req),
		.ext_we_i(x_we), .ext_wdata_i(x_wd), .data_o(data_o),
		.wr_en_o(wr_en_o), .rd_busy_o(rd_busy_o), .wr_busy_o(wr_busy_o),
		.pwrt_active_o(pwrt_active_o), .ext_refused_o(ext_refused_o));
	// 10 MHz clock
	initial
	begin
		forever #50 clk_i = ~clk_i;
	end
	// ****************************************************************
	// Helpers
	// ****************************************************************
	// Xorshift step, fixed start keeps runs repeatable
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	task automatic check(input string nm, input logic [7:0] seen,
		input logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Sample point just after an edge, once flops have settled
	task automatic tick;
		@(posedge clk_i);
		#1;
	endtask
	// One-cycle strobe; idle edge after it so strobes never merge
	task automatic pulse(input logic [6:0] b);
		@(posedge clk_i);
		ctl <= ctl_t'(base | b);
		@(posedge clk_i);
		ctl <= base;
	endtask
	task automatic key(input logic [7:0] b);
		key_d <= b;
		pulse(P_KEY);
	endtask
	// Unlock, start, then measure how long the start bit stands
	task automatic do_write(input logic [7:0] a, input logic [7:0] d,
		input bit sw, input bit ok);
		a_lo <= a;
		a_hi <= seed[7:0]; // High byte must be ignored at 256 bytes
		wd <= d;
		key(sw ? KEY_SECOND : KEY_FIRST);
		key(sw ? KEY_FIRST : KEY_SECOND);
		pulse(P_WR);
		// Busy rises at the edge that takes the strobe
		#1;
		check("wr_start", wr_busy_o, ok);
		n = 0;
		while (wr_busy_o === 1'b1 && n < 50)
		begin
			n++;
			tick();
		end
		if (ok)
		begin
			check("wr_len", 8'(n), 8'(WCNT));
			mem[a] = d;
		end
	endtask
	task automatic do_read(input logic [7:0] a);
		a_lo <= a;
		pulse(P_RD);
		// Read bit stands for one cycle only, look right away
		#1;
		check("rd_bit_set", rd_busy_o, 1'b1);
		tick();
		check("rd_bit_clr", rd_busy_o, 1'b0);
		check("rd_data", data_o, mem[a]);
	endtask
	// External access pulse, refusal flag seen one cycle later
	task automatic ext(input bit we, input bit refused);
		@(posedge clk_i);
		x_req <= 1'b1;
		x_we <= we;
		x_wd <= 8'hC3;
		@(posedge clk_i);
		x_req <= 1'b0;
		#1;
		check("ext_refused", ext_refused_o, refused);
		repeat (6) tick();
	endtask
	// Watchdog sized well past the expected run length
	initial
	begin
		#2000000;
		errors++;
		tally_and_finish();
	end
	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial
	begin
		repeat (3) @(posedge clk_i);
		rst_b_i <= 1'b1;
		tick();
		check("wr_en_rst", wr_en_o, 1'b0);
		check("data_rst", data_o, DATA_RST);
		check("pwrt_on", pwrt_active_o, 1'b1);
		// Correct sequence inside the power-up window is ignored
		pulse(P_WSET);
		do_write(8'h10, 8'h5A, 0, 0);
		n = 0;
		while (pwrt_active_o !== 1'b0 && n < 40)
		begin
			n++;
			tick();
		end
		check("pwrt_off", pwrt_active_o, 1'b0);
		check("wr_en_set", wr_en_o, 1'b1);
		// Cleared enable refuses, then swapped keys refuse
		pulse(P_WCLR);
		do_write(8'h10, 8'h5A, 0, 0);
		pulse(P_WSET);
		do_write(8'h10, 8'h5A, 1, 0);
		// Boundary addresses then random bytes
		for (int i = 0; i < 8; i++)
		begin
			seed = xs(seed);
			ad[i] = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : seed[15:8];
			do_write(ad[i], (i == 1) ? 8'hFF : seed[23:16], 0, 1);
		end
		foreach (ad[i]) do_read(ad[i]);
		do_write(ad[0], 8'hA5, 0, 1);
		do_read(ad[0]);
		do_read(ad[1]);
		// Refresh pass: read a byte and write it straight back
		do_read(ad[2]);
		do_write(ad[2], mem[ad[2]], 0, 1);
		do_read(ad[2]);
		// Either select set keeps the array out of reach
		base = '0;
		base.mem_space_sel = 1'b1;
		do_write(ad[1], 8'h11, 0, 0);
		base = '0;
		base.cfg_space_sel = 1'b1;
		do_write(ad[1], 8'h22, 0, 0);
		// Read strobe outside data space must not start a read
		base = '0;
		base.mem_space_sel = 1'b1;
		pulse(P_RD);
		#1;
		check("rd_refused", rd_busy_o, 1'b0);
		// Refused attempt above used up the unlock: bare start fails
		base = '0;
		pulse(P_WR);
		#1;
		check("wr_stale", wr_busy_o, 1'b0);
		do_read(ad[1]);
		// Protect blocks the programmer only, never the CPU
		cp <= 1'b1;
		ext(0, 1);
		ext(1, 1);
		do_read(ad[1]);
		do_write(8'h33, 8'h96, 0, 1);
		do_read(8'h33);
		cp <= 1'b0;
		a_lo <= 8'h33;
		ext(0, 0);
		check("ext_read", data_o, mem[8'h33]);
		tally_and_finish();
	end
endmodule
